// ==== rtl/ebtsp_params.svh ====
// Constants for the eight-bit timer with shared prescaler.
`ifndef EBTSP_PARAMS_SVH
`define EBTSP_PARAMS_SVH

// Instruction period is the system clock divided by four.
`define EBTSP_INSTR_DIV_LAST 2'h3
`define EBTSP_DIV_ZERO 2'h0
`define EBTSP_DIV_ONE 2'h1

// Counter wrap points.
`define EBTSP_COUNT_MAX 8'hFF
`define EBTSP_COUNT_ZERO 8'h00
`define EBTSP_COUNT_ONE 8'h01

// Increment inhibit after a count write, in instruction periods.
`define EBTSP_INHIBIT_PERIODS 2'h2
`define EBTSP_INHIBIT_ONE 2'h1
`define EBTSP_INHIBIT_NONE 2'h0

// Prescaler allocation codes.
`define EBTSP_ALLOC_TIMER 1'b0
`define EBTSP_ALLOC_WATCHDOG 1'b1

// Prescaler mask arithmetic.
`define EBTSP_MASK_BASE_TIMER 9'h002
`define EBTSP_MASK_BASE_WDT 9'h001
`define EBTSP_MASK_ONE 9'h001

// Fixed interrupt vector and its reset value.
`define EBTSP_VECTOR 13'h0004
`define EBTSP_VECTOR_RESET 13'h0000

`endif

// ==== rtl/ebtsp_pkg.sv ====
// Types shared by the eight-bit timer with shared prescaler.
package ebtsp_pkg;
    typedef logic [7:0] ebtsp_count_type;
    typedef logic [2:0] ebtsp_ratio_type;
    typedef logic [12:0] ebtsp_addr_type;
    typedef enum logic [0:0]
    {
        EBTSP_IDLE = 1'b0,
        EBTSP_SERVICE = 1'b1
    } ebtsp_state_type;
endpackage

// ==== rtl/ebtsp_prescaler.sv ====
// Shared prescaler: a stepped, clearable synchronous count with a masked tap output.
`timescale 1ns/10ps
`include "ebtsp_params.svh"
module ebtsp_prescaler
#(
    parameter int WIDTH = 8
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic step,
    input wire logic [WIDTH-1:0] tap_mask,
    output logic tap_pulse,
    output logic [WIDTH-1:0] count_value
);
    import ebtsp_pkg::*;

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    wire tap_hit = (cnt_reg & tap_mask) == tap_mask;

    if (WIDTH < 8)
    begin : g_width_check
        $error("Prescaler needs at least eight bits for the 1:256 ratio.");
    end

    ////////////////////////////////////////////////////////////////////////
    // The tap fires on the step that rolls the masked bits over, so the
    // divide ratio is one more than the mask.
    assign tap_pulse = step && !clear && tap_hit;
    assign cnt_next = clear ? '0 : (step ? cnt_reg + 1'b1 : cnt_reg);
    assign count_value = cnt_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// ==== rtl/ebtsp_timer.sv ====
// Eight-bit timer/counter with shared prescaler and flat interrupt entry.
`timescale 1ns/10ps
`include "ebtsp_params.svh"
module ebtsp_timer
#(
    parameter int N_SRC = 1,
    parameter int PSC_WIDTH = 8
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic sleep_mode,
    input wire logic clock_source_select,
    input wire logic count_edge_select,
    input wire logic prescaler_allocation,
    input wire ebtsp_pkg::ebtsp_ratio_type prescaler_ratio_field,
    input wire logic external_count_pin,
    input wire logic count_wr,
    input wire ebtsp_pkg::ebtsp_count_type count_wdata,
    output ebtsp_pkg::ebtsp_count_type count_register,
    output logic overflow_flag,
    input wire logic overflow_flag_clear,
    input wire logic overflow_interrupt_enable,
    output logic overflow_int_request,
    input wire logic watchdog_clear_instruction,
    input wire logic watchdog_osc_tick,
    output logic watchdog_tick,
    output logic watchdog_counter_clear,
    input wire logic global_int_enable,
    input wire logic [N_SRC-1:0] other_int_request,
    input wire logic return_from_interrupt,
    output logic irq_take,
    output ebtsp_pkg::ebtsp_addr_type irq_vector,
    output logic in_service
);
    import ebtsp_pkg::*;

    if (N_SRC < 1)
    begin : g_src_check
        $error("At least one other interrupt source port is needed.");
    end
    if (PSC_WIDTH != 8)
    begin : g_psc_check
        $error("The shared prescaler is eight bits wide.");
    end

    function automatic logic [PSC_WIDTH-1:0] psc_mask(input logic [8:0] base, input ebtsp_ratio_type ratio);
        logic [8:0] m;
        m = (base << ratio) - `EBTSP_MASK_ONE;
        return m[PSC_WIDTH-1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Instruction period divider, stopped in sleep.
    logic [1:0] div_reg;
    logic [1:0] div_next;
    wire instr_tick = !sleep_mode && (div_reg == `EBTSP_INSTR_DIV_LAST);

    assign div_next = sleep_mode ? div_reg : div_reg + `EBTSP_DIV_ONE;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            div_reg <= `EBTSP_DIV_ZERO;
        else
            div_reg <= div_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // External pin: two-stage synchroniser, then a third stage for edges.
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic pin_s3_reg;
    wire pin_rise = pin_s2_reg && !pin_s3_reg;
    wire pin_fall = !pin_s2_reg && pin_s3_reg;
    wire ext_edge = count_edge_select ? pin_fall : pin_rise;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
        end
        else
        begin
            pin_s1_reg <= external_count_pin;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Source select and the shared prescaler.
    wire to_timer = prescaler_allocation == `EBTSP_ALLOC_TIMER;
    wire src_tick = !sleep_mode && (clock_source_select ? ext_edge : instr_tick);
    wire psc_step = to_timer ? src_tick : watchdog_osc_tick;
    wire psc_clear = to_timer ? count_wr : watchdog_clear_instruction;
    wire [PSC_WIDTH-1:0] timer_mask = psc_mask(`EBTSP_MASK_BASE_TIMER, prescaler_ratio_field);
    wire [PSC_WIDTH-1:0] wdt_mask = psc_mask(`EBTSP_MASK_BASE_WDT, prescaler_ratio_field);
    wire [PSC_WIDTH-1:0] tap_mask = to_timer ? timer_mask : wdt_mask;
    logic psc_out;
    logic [PSC_WIDTH-1:0] psc_count;

    // The count only feeds the watch logic below; no software path reads it.
    ebtsp_prescaler #(.WIDTH(PSC_WIDTH)) u_psc
    (
        .clk(clk),
        .rstn(rstn),
        .clear(psc_clear),
        .step(psc_step),
        .tap_mask(tap_mask),
        .tap_pulse(psc_out),
        .count_value(psc_count)
    );

    wire cnt_step = to_timer ? psc_out : src_tick;

    ////////////////////////////////////////////////////////////////////////
    // Increment inhibit after a software write.
    logic [1:0] inhibit_reg;
    logic [1:0] inhibit_next;
    wire inhibited = inhibit_reg != `EBTSP_INHIBIT_NONE;

    // The write cycle itself reloads the count, so a tick there is moot.
    assign inhibit_next = count_wr ? `EBTSP_INHIBIT_PERIODS :
                          (instr_tick && inhibited) ? inhibit_reg - `EBTSP_INHIBIT_ONE : inhibit_reg;

    ////////////////////////////////////////////////////////////////////////
    // Count register and overflow flag.
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic flag_reg;
    logic flag_next;
    wire inc_fire = cnt_step && !inhibited && !sleep_mode;
    wire overflow_evt = inc_fire && !count_wr && (count_reg == `EBTSP_COUNT_MAX);

    assign count_next = count_wr ? count_wdata : (inc_fire ? count_reg + `EBTSP_COUNT_ONE : count_reg);
    // A clear in the same cycle as an overflow loses, so no event is dropped.
    assign flag_next = overflow_evt || (flag_reg && !overflow_flag_clear);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_reg <= `EBTSP_COUNT_ZERO;
            flag_reg <= 1'b0;
            inhibit_reg <= `EBTSP_INHIBIT_NONE;
        end
        else
        begin
            count_reg <= count_next;
            flag_reg <= flag_next;
            inhibit_reg <= inhibit_next;
        end
    end

    assign count_register = count_reg;
    assign overflow_flag = flag_reg;
    assign overflow_int_request = flag_reg && overflow_interrupt_enable;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog side outputs, registered pulses.
    logic wdt_tick_reg;
    logic wdt_clr_reg;
    wire wdt_tick_next = to_timer ? watchdog_osc_tick : psc_out;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wdt_tick_reg <= 1'b0;
            wdt_clr_reg <= 1'b0;
        end
        else
        begin
            wdt_tick_reg <= wdt_tick_next;
            wdt_clr_reg <= watchdog_clear_instruction;
        end
    end

    assign watchdog_tick = wdt_tick_reg;
    assign watchdog_counter_clear = wdt_clr_reg;

    ////////////////////////////////////////////////////////////////////////
    // Flat interrupt entry. Context is not saved here; the service routine
    // must keep the accumulator and status itself.
    ebtsp_state_type state_reg;
    ebtsp_state_type state_next;
    logic take_reg;
    ebtsp_addr_type vector_reg;
    ebtsp_addr_type vector_next;
    // Plain OR: the core has no notion of which source came first.
    wire any_request = overflow_int_request || (|other_int_request);
    wire accept = (state_reg == EBTSP_IDLE) && global_int_enable && any_request && !sleep_mode;

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            EBTSP_IDLE:
            begin
                if (accept)
                    state_next = EBTSP_SERVICE;
            end
            EBTSP_SERVICE:
            begin
                if (return_from_interrupt)
                    state_next = EBTSP_IDLE;
            end
        endcase
    end

    assign vector_next = accept ? `EBTSP_VECTOR : vector_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= EBTSP_IDLE;
            take_reg <= 1'b0;
            vector_reg <= `EBTSP_VECTOR_RESET;
        end
        else
        begin
            state_reg <= state_next;
            take_reg <= accept;
            vector_reg <= vector_next;
        end
    end

    assign irq_take = take_reg;
    assign irq_vector = vector_reg;
    assign in_service = state_reg == EBTSP_SERVICE;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    wrap_zero_a: assert property (overflow_evt |=> count_reg == `EBTSP_COUNT_ZERO)
        else $error("Counter did not wrap to zero.");
    flag_set_a: assert property (overflow_evt |=> flag_reg)
        else $error("Overflow flag not set on overflow.");
    flag_hold_a: assert property (flag_reg && !overflow_flag_clear |=> flag_reg)
        else $error("Overflow flag dropped without a clear.");
    req_gate_a: assert property (overflow_int_request == (flag_reg && overflow_interrupt_enable))
        else $error("Request does not follow flag and enable.");
    // Five cycles is the shortest gap, since an external edge may land just after the second tick.
    write_inhibit_a: assert property (count_wr |=> (!inc_fire) [*5])
        else $error("Counter advanced inside the write inhibit.");
    bypass_step_a: assert property (!to_timer && src_tick && !inhibited |-> inc_fire)
        else $error("Bypassed counter missed a source tick.");
    psc_write_clr_a: assert property (to_timer && count_wr |=> psc_count == '0)
        else $error("Count write did not clear the prescaler.");
    psc_wdt_clr_a: assert property (!to_timer && watchdog_clear_instruction |=> psc_count == '0)
        else $error("Watchdog clear did not clear the prescaler.");
    sleep_stop_a: assert property (sleep_mode |=> $stable(count_reg) || $past(count_wr))
        else $error("Counter moved while asleep.");
    vector_jump_a: assert property (accept |=> irq_take && irq_vector == `EBTSP_VECTOR)
        else $error("Accepted interrupt did not go to the vector.");
    no_nest_a: assert property (in_service && !return_from_interrupt |=> !irq_take && in_service)
        else $error("Interrupt taken while one is in service.");
    psc_ratio_a: assert property (to_timer && psc_out && !psc_clear |-> (psc_count & timer_mask) == timer_mask)
        else $error("Prescaler fired off its ratio.");
    ext_edge_a: assert property (clock_source_select && !sleep_mode && ext_edge |-> src_tick)
        else $error("Pin edge did not make a source tick.");
    wdt_pass_a: assert property (to_timer |=> watchdog_tick == $past(watchdog_osc_tick))
        else $error("Watchdog tick did not pass straight through.");
    wdt_clear_a: assert property (watchdog_clear_instruction |=> watchdog_counter_clear)
        else $error("Watchdog clear did not reach the watchdog counter.");
    take_once_a: assert property (irq_take |=> !irq_take)
        else $error("Interrupt taken twice in a row.");

    overflow_c: cover property (overflow_evt ##1 overflow_int_request);
    take_ret_c: cover property (irq_take ##[1:20] return_from_interrupt);
    ext_count_c: cover property (clock_source_select && inc_fire);
    psc_div_c: cover property (to_timer && prescaler_ratio_field == 3'h7 && inc_fire);
    wdt_tick_c: cover property (!to_timer && psc_out);
endmodule

// ==== sim/ebtsp_timer_tb.sv ====
// Self-checking testbench for the eight-bit timer with shared prescaler.
`timescale 1ns/10ps
module ebtsp_timer_tb;
    import ebtsp_pkg::*;
    logic clk, rstn, sleep_mode, clock_source_select, count_edge_select, prescaler_allocation;
    ebtsp_ratio_type prescaler_ratio_field;
    logic external_count_pin, count_wr, overflow_flag, overflow_flag_clear, overflow_interrupt_enable;
    ebtsp_count_type count_wdata, count_register;
    logic overflow_int_request, watchdog_clear_instruction, watchdog_osc_tick, watchdog_tick;
    logic watchdog_counter_clear, global_int_enable, return_from_interrupt, irq_take, in_service;
    logic [0:0] other_int_request;
    ebtsp_addr_type irq_vector;
    int fails, num_checks;

    ebtsp_timer DUT
    (
        .clk(clk), .rstn(rstn), .sleep_mode(sleep_mode), .clock_source_select(clock_source_select),
        .count_edge_select(count_edge_select), .prescaler_allocation(prescaler_allocation),
        .prescaler_ratio_field(prescaler_ratio_field), .external_count_pin(external_count_pin),
        .count_wr(count_wr), .count_wdata(count_wdata), .count_register(count_register),
        .overflow_flag(overflow_flag), .overflow_flag_clear(overflow_flag_clear),
        .overflow_interrupt_enable(overflow_interrupt_enable), .overflow_int_request(overflow_int_request),
        .watchdog_clear_instruction(watchdog_clear_instruction), .watchdog_osc_tick(watchdog_osc_tick),
        .watchdog_tick(watchdog_tick), .watchdog_counter_clear(watchdog_counter_clear),
        .global_int_enable(global_int_enable), .other_int_request(other_int_request),
        .return_from_interrupt(return_from_interrupt), .irq_take(irq_take), .irq_vector(irq_vector),
        .in_service(in_service)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        num_checks++;
        if (a !== e)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask

    // Inputs move 1 ns after the rising edge, so outputs read here have settled.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_change(output int c);
        ebtsp_count_type prev;
        prev = count_register;
        c = 0;
        while (count_register === prev)
        begin
            tick(1);
            c++;
            if (c > 2100)
            begin
                fails++;
                report_and_stop();
            end
        end
    endtask

    task automatic wr(input ebtsp_count_type v);
        count_wdata = v;
        count_wr = 1'b1;
        tick(1);
        count_wr = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({count_register, 6'h00, overflow_flag, overflow_int_request}, 16'h0000);
        chk({irq_vector, irq_take, in_service, 1'b0}, 16'h0000);
    endtask

    task automatic t_rates();
        int c;
        prescaler_allocation = 1'b1;
        wait_change(c);
        wait_change(c);
        chk(c[15:0], 16'h0004);
        prescaler_allocation = 1'b0;
        for (int n = 0; n < 8; n++)
        begin
            prescaler_ratio_field = n[2:0];
            wait_change(c);
            wait_change(c);
            chk(c[15:0], 16'h0008 << n);
        end
    endtask

    task automatic t_inhibit();
        int c;
        prescaler_allocation = 1'b1;
        wait_change(c);
        wr(8'h10);
        tick(8);
        chk({8'h00, count_register}, 16'h0010);
        wait_change(c);
        chk({8'h00, count_register}, 16'h0011);
        chk({15'h0000, c <= 5}, 16'h0001);
        // A stale prescaler would cut the first period short at the slowest ratio.
        prescaler_allocation = 1'b0;
        prescaler_ratio_field = 3'h7;
        tick(20);
        wr(8'h20);
        wait_change(c);
        chk({15'h0000, c >= 1015 && c <= 1030}, 16'h0001);
    endtask

    task automatic t_overflow();
        int c;
        prescaler_allocation = 1'b1;
        wr(8'hFE);
        wait_change(c);
        chk({7'h00, overflow_flag, count_register}, 16'h00FF);
        wait_change(c);
        chk({6'h00, overflow_flag, overflow_int_request, count_register}, 16'h0200);
        clock_source_select = 1'b1;
        tick(10);
        chk({15'h0000, overflow_flag}, 16'h0001);
        overflow_interrupt_enable = 1'b1;
        tick(1);
        chk({15'h0000, overflow_int_request}, 16'h0001);
    endtask

    task automatic t_irq();
        global_int_enable = 1'b1;
        tick(1);
        chk({irq_vector, irq_take, in_service, 1'b0}, 16'h0026);
        repeat (6)
        begin
            tick(1);
            chk({15'h0000, irq_take}, 16'h0000);
        end
        return_from_interrupt = 1'b1;
        tick(1);
        return_from_interrupt = 1'b0;
        chk({15'h0000, in_service}, 16'h0000);
        tick(1);
        chk({14'h0000, irq_take, in_service}, 16'h0003);
        return_from_interrupt = 1'b1;
        overflow_flag_clear = 1'b1;
        tick(1);
        return_from_interrupt = 1'b0;
        overflow_flag_clear = 1'b0;
        chk({14'h0000, overflow_flag, overflow_int_request}, 16'h0000);
        tick(1);
        chk({15'h0000, irq_take}, 16'h0000);
        other_int_request = 1'b1;
        tick(1);
        other_int_request = 1'b0;
        chk({14'h0000, irq_take, in_service}, 16'h0003);
        return_from_interrupt = 1'b1;
        tick(1);
        return_from_interrupt = 1'b0;
        global_int_enable = 1'b0;
    endtask

    task automatic t_pin();
        ebtsp_count_type start;
        clock_source_select = 1'b1;
        for (int es = 0; es < 2; es++)
        begin
            count_edge_select = es[0];
            external_count_pin = es[0];
            tick(8);
            start = count_register;
            repeat (5)
            begin
                external_count_pin = ~es[0];
                tick(4);
                external_count_pin = es[0];
                tick(4);
            end
            tick(6);
            chk({8'h00, count_register}, {8'h00, start + 8'h05});
        end
    endtask

    task automatic t_sleep();
        ebtsp_count_type start;
        int c;
        clock_source_select = 1'b0;
        sleep_mode = 1'b1;
        tick(3);
        start = count_register;
        tick(40);
        chk({8'h00, count_register}, {8'h00, start});
        sleep_mode = 1'b0;
        wait_change(c);
    endtask

    task automatic wdt_clr();
        watchdog_clear_instruction = 1'b1;
        tick(1);
        watchdog_clear_instruction = 1'b0;
        chk({15'h0000, watchdog_counter_clear}, 16'h0001);
    endtask

    // Hand the prescaler over both ways in the order software must follow.
    task automatic t_handover();
        wdt_clr();
        prescaler_allocation = 1'b0;
        watchdog_osc_tick = 1'b1;
        tick(1);
        watchdog_osc_tick = 1'b0;
        chk({15'h0000, watchdog_tick}, 16'h0001);
        wdt_clr();
        prescaler_allocation = 1'b1;
        tick(1);
    endtask

    task automatic t_wdt();
        prescaler_ratio_field = 3'h3;
        wdt_clr();
        for (int i = 0; i < 8; i++)
        begin
            watchdog_osc_tick = 1'b1;
            tick(1);
            watchdog_osc_tick = 1'b0;
            chk({15'h0000, watchdog_tick}, {15'h0000, i == 7});
            tick(1);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        fails = 0;
        num_checks = 0;
        rstn = 1'b0;
        {sleep_mode, clock_source_select, count_edge_select, prescaler_allocation} = 4'h0;
        prescaler_ratio_field = 3'h0;
        {external_count_pin, count_wr, overflow_flag_clear, overflow_interrupt_enable} = 4'h0;
        count_wdata = 8'h00;
        {watchdog_clear_instruction, watchdog_osc_tick, global_int_enable, return_from_interrupt} = 4'h0;
        other_int_request = 1'b0;
        repeat (3) @(posedge clk);
        #1 rstn = 1'b1;
        t_reset();
        t_rates();
        t_inhibit();
        t_overflow();
        t_irq();
        t_pin();
        t_sleep();
        t_handover();
        t_wdt();
        report_and_stop();
    end
endmodule
